// file: inc/wtc_map.vh
`ifndef WTC_MAP_VH
`define WTC_MAP_VH
// Cache word layout
`define WTC_ENTRY_W 31
`define WTC_TAG_HI 30
`define WTC_TAG_LO 17
`define WTC_VALID_BIT 16
`define WTC_DATA_HI 15
`define WTC_DATA_LO 0
`define WTC_TAG_W 14
`define WTC_TAG_NORMAL_W 9
`define WTC_INDEX_W 10
`define WTC_ENTRIES 1024
// Clear period
`define WTC_CLEAR_TIME_US 60
`define WTC_CLK_MHZ 200
`define WTC_CLEAR_CYCLES (`WTC_CLEAR_TIME_US * `WTC_CLK_MHZ)
// Limits after master clear cover every page
`define WTC_LOWER_LIMIT_RST 14'h0000
`define WTC_UPPER_LIMIT_RST 14'h3FFF
`endif

// file: logic/wtc_cache.v
`timescale 1ns/1ps
`include "wtc_map.vh"
module wtc_cache #(
  parameter CLEAR_CYCLES = `WTC_CLEAR_CYCLES
) (
  input wire clk_sys_in,
  input wire reset_in,
  // Processor side
  input wire cpu_req_in,
  input wire cpu_write_in,
  input wire extended_mode_in,
  input wire [`WTC_INDEX_W-1:0] page_offset_index_in,
  input wire [`WTC_TAG_W-1:0] physical_page_number_in,
  input wire [15:0] cpu_wdata_in,
  output reg cpu_done_out,
  output reg cpu_hit_out,
  output reg [15:0] internal_cpu_data_bus_out,
  // Control
  input wire clear_cache_in,
  input wire set_lower_limit_in,
  input wire set_upper_limit_in,
  input wire [`WTC_TAG_W-1:0] limit_value_in,
  output reg cache_on_out,
  // Main memory side
  output reg mem_req_out,
  output reg mem_write_out,
  output reg [`WTC_INDEX_W-1:0] mem_offset_out,
  output reg [`WTC_TAG_W-1:0] mem_page_out,
  output reg [15:0] mem_wdata_out,
  input wire mem_ack_in,
  input wire [15:0] mem_rdata_in
);
  localparam ST_IDLE = 3'd0;
  localparam ST_LOOK = 3'd1;
  localparam ST_CMP = 3'd2;
  localparam ST_MEM = 3'd3;
  localparam ST_CLEAR = 3'd4;
  // Wide enough for the full clear time at the clock rate
  localparam CNT_W = 24;

  // Tag compare, masked to nine bits outside extended mode
  function tag_match;
    input [`WTC_TAG_W-1:0] stored;
    input [`WTC_TAG_W-1:0] page;
    input ext;
    begin
      if (ext) begin
        tag_match = (stored == page);
      end else begin
        tag_match = (stored[`WTC_TAG_NORMAL_W-1:0] ==
                     page[`WTC_TAG_NORMAL_W-1:0]);
      end
    end
  endfunction

  // Inclusive page range, checked against both limits
  function page_in_range;
    input [`WTC_TAG_W-1:0] page;
    input [`WTC_TAG_W-1:0] lower;
    input [`WTC_TAG_W-1:0] upper;
    begin
      page_in_range = (page >= lower) && (page <= upper);
    end
  endfunction

  // Packs tag, valid flag and data into one array word
  function [`WTC_ENTRY_W-1:0] entry_word;
    input [`WTC_TAG_W-1:0] tag;
    input valid;
    input [15:0] data;
    begin
      entry_word = {tag, valid, data};
    end
  endfunction

  // Access sequencing and clear state
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [CNT_W-1:0] clear_cnt_q;
  reg [`WTC_INDEX_W-1:0] wipe_idx_q;
  reg wipe_busy_q;
  reg [`WTC_TAG_W-1:0] lower_no_cache_limit_q;
  reg [`WTC_TAG_W-1:0] upper_no_cache_limit_q;

  // Request latched at the idle edge
  reg [`WTC_INDEX_W-1:0] idx_q;
  reg [`WTC_TAG_W-1:0] page_q;
  reg write_q;
  reg ext_q;
  reg [15:0] wdata_q;

  // Array port
  reg ram_we;
  reg [`WTC_INDEX_W-1:0] ram_addr;
  reg [`WTC_ENTRY_W-1:0] ram_wdata;
  wire [`WTC_ENTRY_W-1:0] ram_rdata;

  // Decoded lookup
  wire [`WTC_TAG_W-1:0] stored_page_tag;
  wire stored_valid;
  wire inhibited;
  wire hit;

  assign stored_page_tag = ram_rdata[`WTC_TAG_HI:`WTC_TAG_LO];
  assign stored_valid = ram_rdata[`WTC_VALID_BIT];
  // Inclusive range excluded from caching
  assign inhibited = page_in_range(page_q, lower_no_cache_limit_q,
                                   upper_no_cache_limit_q);
  // Cache off or an inhibited page misses even on a tag match.
  // Word type never enters the decision
  assign hit = stored_valid && tag_match(stored_page_tag, page_q, ext_q)
               && !inhibited && cache_on_out;

  wtc_entry_ram #(
    .ADDR_W(`WTC_INDEX_W),
    .DATA_W(`WTC_ENTRY_W)
  ) u_ram (
    .clk_sys_in(clk_sys_in),
    .wr_en_in(ram_we),
    .addr_in(ram_addr),
    .wr_data_in(ram_wdata),
    .rd_data_out(ram_rdata)
  );

  // Array port steering
  // The wipe owns the port while it runs; accesses in that
  // time find the cache off and go to memory
  always @* begin
    ram_we = 1'b0;
    ram_addr = page_offset_index_in;
    ram_wdata = {`WTC_ENTRY_W{1'b0}};
    if (wipe_busy_q) begin
      ram_we = 1'b1;
      ram_addr = wipe_idx_q;
      ram_wdata = entry_word({`WTC_TAG_W{1'b0}}, 1'b0, 16'h0000);
    end else if (state_q == ST_MEM && mem_ack_in) begin
      ram_addr = idx_q;
      // Inhibited pages and a disabled cache leave the entry alone
      ram_we = !inhibited && cache_on_out;
      ram_wdata = entry_word(page_q, 1'b1,
                             write_q ? wdata_q : mem_rdata_in);
    end else if (state_q != ST_IDLE) begin
      ram_addr = idx_q;
    end
  end

  // Idle takes the request, look lets the array read the
  // indexed word, compare decides hit or memory cycle.
  // The look cycle exists because array data is registered;
  // a combinational array would save it but lengthen the
  // path through the tag compare.
  // Writes go to memory even on a tag match, so main memory
  // never lags the cache.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cpu_req_in) begin
          state_d = ST_LOOK;
        end
      end
      ST_LOOK: begin
        state_d = ST_CMP;
      end
      ST_CMP: begin
        if (!write_q && hit) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_MEM;
        end
      end
      ST_MEM: begin
        if (mem_ack_in) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Latched fields hold until the access ends, so the
  // processor may change its pins once the request is taken
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      idx_q <= {`WTC_INDEX_W{1'b0}};
      page_q <= {`WTC_TAG_W{1'b0}};
      write_q <= 1'b0;
      ext_q <= 1'b0;
      wdata_q <= 16'h0000;
      cpu_done_out <= 1'b0;
      cpu_hit_out <= 1'b0;
      internal_cpu_data_bus_out <= 16'h0000;
      mem_req_out <= 1'b0;
      mem_write_out <= 1'b0;
      mem_offset_out <= {`WTC_INDEX_W{1'b0}};
      mem_page_out <= {`WTC_TAG_W{1'b0}};
      mem_wdata_out <= 16'h0000;
    end else begin
      state_q <= state_d;
      cpu_done_out <= 1'b0;
      cpu_hit_out <= 1'b0;
      if (state_q == ST_IDLE && cpu_req_in) begin
        idx_q <= page_offset_index_in;
        page_q <= physical_page_number_in;
        write_q <= cpu_write_in;
        ext_q <= extended_mode_in;
        wdata_q <= cpu_wdata_in;
      end
      if (state_q == ST_CMP) begin
        if (!write_q && hit) begin
          cpu_done_out <= 1'b1;
          cpu_hit_out <= 1'b1;
          internal_cpu_data_bus_out <=
            ram_rdata[`WTC_DATA_HI:`WTC_DATA_LO];
        end else begin
          // Fields stay put until the acknowledge, as memory
          // may sample them in any cycle of the request
          mem_req_out <= 1'b1;
          mem_write_out <= write_q;
          mem_offset_out <= idx_q;
          mem_page_out <= page_q;
          mem_wdata_out <= wdata_q;
        end
      end
      // Done follows the acknowledge by one cycle
      if (state_q == ST_MEM && mem_ack_in) begin
        mem_req_out <= 1'b0;
        mem_write_out <= 1'b0;
        cpu_done_out <= 1'b1;
        if (!write_q) begin
          internal_cpu_data_bus_out <= mem_rdata_in;
        end
      end
    end
  end

  // Clear sequencing, limit registers and cache enable
  // Reset counts as a clear: the wipe walks all entries one
  // per cycle while the enable timer runs alongside, and the
  // enable waits for whichever of the two ends last.
  // Limits stop both hits and new fills; entries already cached
  // in a widened range stay, missing, until software clears the cache.
  always @(posedge clk_sys_in) begin
    if (reset_in) begin
      clear_cnt_q <= CLEAR_CYCLES[CNT_W-1:0];
      wipe_idx_q <= {`WTC_INDEX_W{1'b0}};
      wipe_busy_q <= 1'b1;
      cache_on_out <= 1'b0;
      lower_no_cache_limit_q <= `WTC_LOWER_LIMIT_RST;
      upper_no_cache_limit_q <= `WTC_UPPER_LIMIT_RST;
    end else begin
      if (set_lower_limit_in) begin
        lower_no_cache_limit_q <= limit_value_in;
      end
      if (set_upper_limit_in) begin
        upper_no_cache_limit_q <= limit_value_in;
      end
      if (clear_cache_in) begin
        // Restart wipe; a fill in flight cannot land while off
        clear_cnt_q <= CLEAR_CYCLES[CNT_W-1:0];
        wipe_idx_q <= {`WTC_INDEX_W{1'b0}};
        wipe_busy_q <= 1'b1;
        cache_on_out <= 1'b0;
      end else begin
        if (wipe_busy_q) begin
          wipe_idx_q <= wipe_idx_q + 1'b1;
          if (&wipe_idx_q) begin
            wipe_busy_q <= 1'b0;
          end
        end
        if (clear_cnt_q != {CNT_W{1'b0}}) begin
          clear_cnt_q <= clear_cnt_q - 1'b1;
        end
        cache_on_out <= (clear_cnt_q == {CNT_W{1'b0}}) && !wipe_busy_q;
      end
    end
  end
endmodule // wtc_cache

// file: logic/wtc_entry_ram.v
`timescale 1ns/1ps
// Single-port entry array, registered read data
module wtc_entry_ram #(
  parameter ADDR_W = 10,
  parameter DATA_W = 31
) (
  input wire clk_sys_in,
  input wire wr_en_in,
  input wire [ADDR_W-1:0] addr_in,
  input wire [DATA_W-1:0] wr_data_in,
  output reg [DATA_W-1:0] rd_data_out
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge clk_sys_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[addr_in];
  end
endmodule // wtc_entry_ram

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk_sys_in = 0, reset_in = 1, cpu_req_in = 0, cpu_write_in = 0;
  reg extended_mode_in = 1, clear_cache_in = 0, set_lower_limit_in = 0;
  reg set_upper_limit_in = 0, mr, mw;
  reg [9:0] page_offset_index_in = 0;
  reg [13:0] physical_page_number_in = 0, limit_value_in = 0;
  reg [15:0] cpu_wdata_in = 0;
  reg [15:0] wd = 0;
  wire cpu_done_out, cpu_hit_out, cache_on_out, mem_req_out, mem_write_out;
  wire mem_ack_in;
  wire [15:0] internal_cpu_data_bus_out, mem_wdata_out, mem_rdata_in;
  wire [9:0] mem_offset_out;
  wire [13:0] mem_page_out;
  integer num_errors = 0, checks_done = 0, i;
  wtc_cache #(.CLEAR_CYCLES(1100)) uut (.clk_sys_in, .reset_in,
    .cpu_req_in, .cpu_write_in, .extended_mode_in, .page_offset_index_in,
    .physical_page_number_in, .cpu_wdata_in, .cpu_done_out, .cpu_hit_out,
    .internal_cpu_data_bus_out, .clear_cache_in, .set_lower_limit_in,
    .set_upper_limit_in, .limit_value_in, .cache_on_out, .mem_req_out,
    .mem_write_out, .mem_offset_out, .mem_page_out, .mem_wdata_out,
    .mem_ack_in, .mem_rdata_in);
  wtc_mem_model mem (.clk_sys_in, .req_in(mem_req_out),
    .page_in(mem_page_out), .off_in(mem_offset_out),
    .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  function [15:0] mf(input [13:0] p, input [9:0] o);
    mf = {p[5:0], o};
  endfunction
  task results;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input w, x, input [13:0] p, input [9:0] o, input [15:0] d,
      input h);
    @(negedge clk_sys_in);
    {cpu_req_in, cpu_write_in, extended_mode_in} = {1'b1, w, x};
    {physical_page_number_in, page_offset_index_in} = {p, o};
    cpu_wdata_in = d;
    {mr, mw} = 2'b00;
    wd = 16'h0000;
    @(negedge clk_sys_in);
    cpu_req_in = 0;
    for (i = 0; i < 99 && cpu_done_out !== 1'b1; i++) begin
      {mr, mw} = {mr | mem_req_out, mw | mem_write_out};
      if (mem_write_out) wd = mem_wdata_out;
      @(negedge clk_sys_in);
    end
    if (i == 99) begin
      num_errors++;
      results;
    end
    chk(cpu_hit_out, h);
    chk(mr, !h);
    chk(mw, w);
    if (w) chk(wd, d);
    if (!w) chk(internal_cpu_data_bus_out, d);
  endtask
  task wait_on;
    for (i = 0; i < 3000 && cache_on_out !== 1'b1; i++) @(negedge clk_sys_in);
    chk(cache_on_out, 1);
    if (i == 3000) begin
      num_errors++;
      results;
    end
  endtask
  task lim(input [13:0] lo, hi);
    @(negedge clk_sys_in);
    {limit_value_in, set_lower_limit_in} = {lo, 1'b1};
    @(negedge clk_sys_in);
    {limit_value_in, set_lower_limit_in, set_upper_limit_in} = {hi, 2'b01};
    @(negedge clk_sys_in);
    set_upper_limit_in = 0;
  endtask
  task t_reset_excl;
    acc(0, 1, 2, 3, mf(2, 3), 0);
    acc(0, 1, 2, 3, mf(2, 3), 0);
  endtask
  task t_share;
    acc(0, 1, 1, 17, mf(1, 17), 0);
    acc(0, 1, 1, 17, mf(1, 17), 1);
    acc(1, 1, 6, 17, 16'hBEEF, 0);
    acc(0, 1, 6, 17, 16'hBEEF, 1);
    acc(0, 1, 1, 17, mf(1, 17), 0);
  endtask
  task t_normal;
    acc(0, 0, 14'h201, 17, mf(1, 17), 1);
    acc(0, 1, 14'h201, 17, mf(14'h201, 17), 0);
  endtask
  task t_clear;
    @(negedge clk_sys_in);
    clear_cache_in = 1;
    @(negedge clk_sys_in);
    clear_cache_in = 0;
    chk(cache_on_out, 0);
    wait_on;
    acc(0, 1, 14'h201, 17, mf(14'h201, 17), 0);
  endtask
  task t_inhibit;
    lim(6, 6);
    acc(0, 1, 6, 5, mf(6, 5), 0);
    acc(0, 1, 6, 5, mf(6, 5), 0);
    acc(0, 1, 7, 5, mf(7, 5), 0);
    acc(0, 1, 7, 5, mf(7, 5), 1);
  endtask
  initial begin
    repeat (5) @(negedge clk_sys_in);
    reset_in = 0;
    wait_on;
    t_reset_excl;
    lim(14'h3FFF, 0);
    t_share;
    t_normal;
    t_clear;
    t_inhibit;
    results;
  end
endmodule // tb_top

// file: tb/wtc_cache_properties.sv
`timescale 1ns/1ps
module wtc_cache_properties #(
  parameter CLEAR_CYCLES = 12000
) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire clear_cache_in,
  input wire cache_on_out,
  input wire cpu_done_out,
  input wire cpu_hit_out,
  input wire [15:0] internal_cpu_data_bus_out,
  input wire mem_req_out,
  input wire mem_write_out,
  input wire [15:0] mem_wdata_out,
  input wire mem_ack_in,
  input wire [15:0] mem_rdata_in
);
  int off_q;
  always @(posedge clk_sys_in)
    off_q <= (reset_in || cache_on_out) ? 0 : off_q + 1;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  sequence s_fill;
    mem_req_out && mem_ack_in;
  endsequence
  sequence s_off8;
    !cache_on_out [*8];
  endsequence
  a_hit_no_mem: assert property (cpu_hit_out |-> cpu_done_out && !mem_req_out
    && !$past(mem_req_out)) else $error("hit with memory cycle");
  a_hit_needs_on: assert property (cpu_hit_out |-> cache_on_out)
    else $error("hit while cache off");
  a_fill_done: assert property (s_fill |=> cpu_done_out && !cpu_hit_out
    && !mem_req_out) else $error("memory answer not finished");
  a_fill_data: assert property (s_fill ##0 !mem_write_out |=>
    internal_cpu_data_bus_out == $past(mem_rdata_in))
    else $error("memory word not returned");
  a_req_holds: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
    && $stable(mem_wdata_out)) else $error("memory request dropped");
  a_clear_off: assert property (clear_cache_in |=> s_off8)
    else $error("cache on during clear");
  a_on_late: assert property ($rose(cache_on_out) |-> off_q >= CLEAR_CYCLES)
    else $error("cache on too early");
  a_done_pulse: assert property (cpu_done_out |=> !cpu_done_out)
    else $error("done longer than one cycle");
endmodule // wtc_cache_properties
bind wtc_cache wtc_cache_properties #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_props (
  .clk_sys_in, .reset_in, .clear_cache_in, .cache_on_out, .cpu_done_out,
  .cpu_hit_out, .internal_cpu_data_bus_out, .mem_req_out, .mem_write_out,
  .mem_wdata_out, .mem_ack_in, .mem_rdata_in);

// file: tb/wtc_mem_model.sv
`timescale 1ns/1ps
module wtc_mem_model (
  input wire clk_sys_in,
  input wire req_in,
  input wire [13:0] page_in,
  input wire [9:0] off_in,
  output reg ack_out = 0,
  output reg [15:0] rdata_out = 0
);
  reg [1:0] n_q = 0;
  // Idle data inverted so a late sample is caught
  always @(negedge clk_sys_in) begin
    n_q <= req_in ? n_q + 1 : 0;
    ack_out <= req_in && n_q == 2;
    rdata_out <= (req_in && n_q == 2) ? {page_in[5:0], off_in} : ~rdata_out;
  end
endmodule // wtc_mem_model
